/* heater_pkg.sv */
// Constants, types and encodings for the heater board control and status block
// Function
// - Drive separate energize permits for center and end coil sections.
// - Drive a three-bit power-setting selection for each coil section.
// - Drive a duty-ratio selection line to the heater board.
// - Any logged heater fault code removes coil energization and raises service call; the all-high warning alone does not.
// - All lines low at power-on, cover closed: code C471, counter 11.
// - Normal operation, missing AC supply: code C472, counter 12.
// - Normal operation, low low high: surge, code C473, counter 13.
// - Normal operation, low high low: switching fault, code C481, counter 14.
// - High low low in normal operation is healthy, nothing logged.
// - All lines high is a low-voltage warning, no code or counter until held 10 ms, then code C474.
// - High high low: input-current low limit, code C490, counter 16.
// - Supply below 75 percent of rated: code C474, counter 17.
// - Cover open, low low, third ignored: code C475, counter 10.
// - Two coil sections, center and ends, controlled independently.
// - Error counter two or more at power-up: no heating, repeated fault.
package heater_pkg;

  localparam int CLK_PERIOD_NS = 4;
  // Status must hold this long before it is decoded
  localparam int FILTER_TIME_NS = 1000;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_W = $clog2(FILTER_CYCLES + 1);
  // All-high held this long is taken as the deep under-voltage case
  localparam int LOW_LIMIT_TIME_US = 10000;
  localparam int LOW_LIMIT_CYCLES = LOW_LIMIT_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int LOW_W = 24;

  localparam int STATUS_W = 3;
  localparam int SEL_W = 3;
  localparam int CODE_W = 16;
  localparam int COUNT_W = 5;

  localparam logic [COUNT_W-1:0] REPEAT_LIMIT = 5'h02;

  // Pattern as {line0, line1, line2}
  localparam logic [STATUS_W-1:0] PAT_LLL = 3'h0;
  localparam logic [STATUS_W-1:0] PAT_LLH = 3'h1;
  localparam logic [STATUS_W-1:0] PAT_LHL = 3'h2;
  localparam logic [STATUS_W-1:0] PAT_LHH = 3'h3;
  localparam logic [STATUS_W-1:0] PAT_HLL = 3'h4;
  localparam logic [STATUS_W-1:0] PAT_HHL = 3'h6;
  localparam logic [STATUS_W-1:0] PAT_HHH = 3'h7;

  localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_C471 = 16'hc471;
  localparam logic [CODE_W-1:0] CODE_C472 = 16'hc472;
  localparam logic [CODE_W-1:0] CODE_C473 = 16'hc473;
  localparam logic [CODE_W-1:0] CODE_C474 = 16'hc474;
  localparam logic [CODE_W-1:0] CODE_C475 = 16'hc475;
  localparam logic [CODE_W-1:0] CODE_C480 = 16'hc480;
  localparam logic [CODE_W-1:0] CODE_C481 = 16'hc481;
  localparam logic [CODE_W-1:0] CODE_C490 = 16'hc490;

  localparam logic [COUNT_W-1:0] CNT_NONE = 5'h00;
  localparam logic [COUNT_W-1:0] CNT_C475 = 5'h0a;
  localparam logic [COUNT_W-1:0] CNT_C471 = 5'h0b;
  localparam logic [COUNT_W-1:0] CNT_C472 = 5'h0c;
  localparam logic [COUNT_W-1:0] CNT_C473 = 5'h0d;
  localparam logic [COUNT_W-1:0] CNT_C481 = 5'h0e;
  localparam logic [COUNT_W-1:0] CNT_C480 = 5'h0f;
  localparam logic [COUNT_W-1:0] CNT_C490 = 5'h10;
  localparam logic [COUNT_W-1:0] CNT_C474 = 5'h11;

  typedef struct packed {
    logic line0;
    logic line1;
    logic line2;
  } status_s;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [COUNT_W-1:0] count;
  } err_s;

  typedef struct packed {
    logic [SEL_W-1:0] sec1;
    logic [SEL_W-1:0] sec2;
    logic duty;
  } power_s;

  typedef enum logic [1:0] {
    S_INIT = 2'b00,
    S_RUN = 2'b01,
    S_FAULT = 2'b10
  } state_e;

endpackage

/* status_filter.sv */
// Two-stage synchronizer and stability filter for the heater status lines
`timescale 1ns/1ns
module status_filter
  import heater_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [STATUS_W-1:0] raw,
  output logic [STATUS_W-1:0] stable,
  output logic valid
);

  logic [STATUS_W-1:0] sync1_q, sync2_q, cand_q, cand_d, stable_q, stable_d;
  logic [FILTER_W-1:0] cnt_q, cnt_d;
  logic valid_q, valid_d;

  always_comb begin
    cand_d = sync2_q;
    cnt_d = cnt_q;
    stable_d = stable_q;
    valid_d = valid_q;
    if (sync2_q != cand_q) begin
      cnt_d = '0;
    end else if (cnt_q != FILTER_W'(FILTER_CYCLES)) begin
      cnt_d = cnt_q + FILTER_W'(1);
    end else begin
      stable_d = cand_q;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      cand_q <= '0;
      cnt_q <= '0;
      stable_q <= '0;
      valid_q <= 1'b0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      cand_q <= cand_d;
      cnt_q <= cnt_d;
      stable_q <= stable_d;
      valid_q <= valid_d;
    end
  end

  assign stable = stable_q;
  assign valid = valid_q;

  property p_filter_hold;
    @(posedge clock) disable iff (reset)
      $changed(stable_q) |-> $past(cnt_q) == FILTER_W'(FILTER_CYCLES);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("status taken before it was stable");

endmodule

/* heater_ctrl.sv */
// Logic-board side control and status decode for the induction heater board
`timescale 1ns/1ns
module heater_ctrl
  import heater_pkg::*;
#(
  parameter int LOW_LIMIT_CYC = LOW_LIMIT_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic heat_req_center,
  input wire logic heat_req_ends,
  input wire logic [SEL_W-1:0] power_req_center,
  input wire logic [SEL_W-1:0] power_req_ends,
  input wire logic duty_req,
  input wire logic cover_open,
  input wire logic [COUNT_W-1:0] stored_count,
  input wire logic heater_status0,
  input wire logic heater_status1,
  input wire logic heater_status2,
  output logic coil_sec1_permit,
  output logic coil_sec2_permit,
  output logic sec1_power_sel0,
  output logic sec1_power_sel1,
  output logic sec1_power_sel2,
  output logic sec2_power_sel0,
  output logic sec2_power_sel1,
  output logic sec2_power_sel2,
  output logic duty_ratio_sel,
  output logic service_call,
  output logic repeated_fault,
  output logic low_voltage_warn,
  output logic error_valid,
  output logic [CODE_W-1:0] error_code,
  output logic [COUNT_W-1:0] error_count
);

  status_s pat;
  logic [STATUS_W-1:0] stable;
  logic valid;

  status_filter u_filter (
    .clock(clock),
    .reset(reset),
    .raw({heater_status0, heater_status1, heater_status2}),
    .stable(stable),
    .valid(valid)
  );

  assign pat = status_s'(stable);

  state_e state_q, state_d;
  err_s err_q, err_d;
  power_s pwr_q, pwr_d;
  logic sec1_q, sec1_d, sec2_q, sec2_d;
  logic rep_q, rep_d, warn_q, warn_d, evt_q, evt_d;
  logic [LOW_W-1:0] low_q, low_d;
  logic hit;
  err_s hit_err;

  // Fault decode, only looked at once the pattern is stable
  always_comb begin
    hit = 1'b0;
    hit_err = '{code: CODE_NONE, count: CNT_NONE};
    if (cover_open) begin
      if (!pat.line0 && !pat.line1) begin
        hit = 1'b1;
        hit_err = '{code: CODE_C475, count: CNT_C475};
      end
    end else begin
      case (stable)
        PAT_LLL: begin
          hit = 1'b1;
          hit_err = '{code: CODE_C472, count: CNT_C472};
        end
        PAT_LLH: begin
          hit = 1'b1;
          hit_err = '{code: CODE_C473, count: CNT_C473};
        end
        PAT_LHL: begin
          hit = 1'b1;
          hit_err = '{code: CODE_C481, count: CNT_C481};
        end
        PAT_LHH: begin
          hit = 1'b1;
          hit_err = '{code: CODE_C480, count: CNT_C480};
        end
        PAT_HHL: begin
          hit = 1'b1;
          hit_err = '{code: CODE_C490, count: CNT_C490};
        end
        PAT_HHH: begin
          if (low_q == LOW_W'(LOW_LIMIT_CYC)) begin
            hit = 1'b1;
            hit_err = '{code: CODE_C474, count: CNT_C474};
          end
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    err_d = err_q;
    rep_d = rep_q;
    evt_d = 1'b0;
    warn_d = 1'b0;
    low_d = '0;
    case (state_q)
      S_INIT: begin
        if (stored_count >= REPEAT_LIMIT) begin
          state_d = S_FAULT;
          rep_d = 1'b1;
        end else if (valid) begin
          if (!cover_open && stable == PAT_LLL) begin
            state_d = S_FAULT;
            err_d = '{code: CODE_C471, count: CNT_C471};
            evt_d = 1'b1;
          end else begin
            state_d = S_RUN;
          end
        end
      end
      S_RUN: begin
        if (!cover_open && stable == PAT_HHH) begin
          warn_d = 1'b1;
          if (low_q != LOW_W'(LOW_LIMIT_CYC)) begin
            low_d = low_q + LOW_W'(1);
          end else begin
            low_d = low_q;
          end
        end
        if (hit) begin
          state_d = S_FAULT;
          err_d = hit_err;
          evt_d = 1'b1;
        end
      end
      S_FAULT: begin
        state_d = S_FAULT;
      end
      default: begin
        state_d = S_FAULT;
      end
    endcase
  end

  // Outputs only move in RUN; a latched fault holds every drive off until reset
  always_comb begin
    sec1_d = heat_req_center && state_d == S_RUN;
    sec2_d = heat_req_ends && state_d == S_RUN;
    pwr_d = '{sec1: '0, sec2: '0, duty: 1'b0};
    if (state_d == S_RUN) begin
      pwr_d = '{sec1: power_req_center, sec2: power_req_ends, duty: duty_req};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= S_INIT;
      err_q <= '{code: CODE_NONE, count: CNT_NONE};
      rep_q <= 1'b0;
      evt_q <= 1'b0;
      warn_q <= 1'b0;
      low_q <= '0;
      sec1_q <= 1'b0;
      sec2_q <= 1'b0;
      pwr_q <= '{sec1: '0, sec2: '0, duty: 1'b0};
    end else begin
      state_q <= state_d;
      err_q <= err_d;
      rep_q <= rep_d;
      evt_q <= evt_d;
      warn_q <= warn_d;
      low_q <= low_d;
      sec1_q <= sec1_d;
      sec2_q <= sec2_d;
      pwr_q <= pwr_d;
    end
  end

  assign coil_sec1_permit = sec1_q;
  assign coil_sec2_permit = sec2_q;
  assign sec1_power_sel0 = pwr_q.sec1[0];
  assign sec1_power_sel1 = pwr_q.sec1[1];
  assign sec1_power_sel2 = pwr_q.sec1[2];
  assign sec2_power_sel0 = pwr_q.sec2[0];
  assign sec2_power_sel1 = pwr_q.sec2[1];
  assign sec2_power_sel2 = pwr_q.sec2[2];
  assign duty_ratio_sel = pwr_q.duty;
  assign service_call = state_q == S_FAULT;
  assign repeated_fault = rep_q;
  assign low_voltage_warn = warn_q;
  assign error_valid = evt_q;
  assign error_code = err_q.code;
  assign error_count = err_q.count;

  sequence s_run_checked(logic [STATUS_W-1:0] p);
    state_q == S_RUN && valid && !cover_open && stable == p;
  endsequence

  property p_fault_off;
    @(posedge clock) disable iff (reset)
      service_call |-> !coil_sec1_permit && !coil_sec2_permit && !duty_ratio_sel;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("coil driven during fault");

  property p_c471;
    @(posedge clock) disable iff (reset)
      state_q == S_INIT && stored_count < REPEAT_LIMIT && valid && !cover_open
      && stable == PAT_LLL |=> service_call && error_valid && error_code == CODE_C471
      && error_count == CNT_C471;
  endproperty
  a_c471: assert property (p_c471) else $error("init fault not logged");

  property p_c472;
    @(posedge clock) disable iff (reset)
      s_run_checked(PAT_LLL) |=> error_code == CODE_C472 && error_count == CNT_C472;
  endproperty
  a_c472: assert property (p_c472) else $error("supply loss not logged");

  property p_c473;
    @(posedge clock) disable iff (reset)
      s_run_checked(PAT_LLH) |=> error_code == CODE_C473 && error_count == CNT_C473;
  endproperty
  a_c473: assert property (p_c473) else $error("surge not logged");

  property p_c481;
    @(posedge clock) disable iff (reset)
      s_run_checked(PAT_LHL) |=> error_code == CODE_C481 ##1 !error_valid;
  endproperty
  a_c481: assert property (p_c481) else $error("switch fault not logged once");

  property p_healthy;
    @(posedge clock) disable iff (reset)
      s_run_checked(PAT_HLL) |=> !error_valid && !service_call;
  endproperty
  a_healthy: assert property (p_healthy) else $error("healthy status raised error");

  property p_warn;
    @(posedge clock) disable iff (reset)
      s_run_checked(PAT_HHH) ##0 low_q != LOW_W'(LOW_LIMIT_CYC)
      |=> low_voltage_warn && !error_valid;
  endproperty
  a_warn: assert property (p_warn) else $error("low voltage warning wrong");

  property p_c490;
    @(posedge clock) disable iff (reset)
      s_run_checked(PAT_HHL) |=> error_code == CODE_C490 && error_count == CNT_C490;
  endproperty
  a_c490: assert property (p_c490) else $error("current low limit not logged");

  property p_c475;
    @(posedge clock) disable iff (reset)
      state_q == S_RUN && valid && cover_open && !pat.line0 && !pat.line1
      |=> error_code == CODE_C475 && error_count == CNT_C475;
  endproperty
  a_c475: assert property (p_c475) else $error("cover open fault not logged");

  property p_repeat;
    @(posedge clock) disable iff (reset)
      state_q == S_INIT && stored_count >= REPEAT_LIMIT
      |=> (repeated_fault && service_call) [*2];
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeated fault not raised");

  property p_split;
    @(posedge clock) disable iff (reset)
      state_q == S_RUN && state_d == S_RUN
      |=> coil_sec1_permit == $past(heat_req_center)
      && coil_sec2_permit == $past(heat_req_ends);
  endproperty
  a_split: assert property (p_split) else $error("section permit not independent");

endmodule

/* heater_board_model.sv */
// Behavioural heater board: takes the permits and settings, reports three status levels
`timescale 1ns/1ns
module heater_board_model
  import heater_pkg::*;
(
  input wire logic clock,
  input wire logic sec1_on,
  input wire logic sec2_on,
  input wire logic [SEL_W-1:0] sec1_sel,
  input wire logic [SEL_W-1:0] sec2_sel,
  input wire logic duty,
  input wire logic [STATUS_W-1:0] fault_pat,
  input wire logic fault_on,
  output status_s status
);
  // Delivered setting per section; a section without permit delivers nothing
  logic [SEL_W:0] power1_q;
  logic [SEL_W:0] power2_q;
  always_ff @(posedge clock) begin
    power1_q <= sec1_on ? {duty, sec1_sel} : '0;
    power2_q <= sec2_on ? {duty, sec2_sel} : '0;
  end
  // Plain levels; a healthy board holds high, low, low
  assign status = fault_on ? status_s'(fault_pat) : status_s'(PAT_HLL);
endmodule

/* tb.sv */
// Self-checking testbench for the heater control and status block
`timescale 1ns/1ns
module tb
  import heater_pkg::*;
;
  localparam int LOWC = 20;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic heat_req_center = 1'b0;
  logic heat_req_ends = 1'b0;
  logic [SEL_W-1:0] power_req_center = 3'h0;
  logic [SEL_W-1:0] power_req_ends = 3'h0;
  logic duty_req = 1'b0;
  logic cover_open = 1'b0;
  logic [COUNT_W-1:0] stored_count = 5'h00;
  logic [STATUS_W-1:0] fault_pat = 3'h0;
  logic fault_on = 1'b0;
  status_s status;
  logic p1, p2, s10, s11, s12, s20, s21, s22, duty_o, service_call, repeated_fault;
  logic low_voltage_warn, error_valid;
  logic [CODE_W-1:0] error_code;
  logic [COUNT_W-1:0] error_count;
  int fails = 0;
  int checked = 0;

  always #2 clock = ~clock;

  heater_ctrl #(.LOW_LIMIT_CYC(LOWC)) heater_ctrl_i (.clock(clock), .reset(reset),
    .heat_req_center(heat_req_center), .heat_req_ends(heat_req_ends),
    .power_req_center(power_req_center), .power_req_ends(power_req_ends),
    .duty_req(duty_req), .cover_open(cover_open), .stored_count(stored_count),
    .heater_status0(status.line0), .heater_status1(status.line1),
    .heater_status2(status.line2), .coil_sec1_permit(p1), .coil_sec2_permit(p2),
    .sec1_power_sel0(s10), .sec1_power_sel1(s11), .sec1_power_sel2(s12),
    .sec2_power_sel0(s20), .sec2_power_sel1(s21), .sec2_power_sel2(s22),
    .duty_ratio_sel(duty_o), .service_call(service_call), .repeated_fault(repeated_fault),
    .low_voltage_warn(low_voltage_warn), .error_valid(error_valid),
    .error_code(error_code), .error_count(error_count));

  heater_board_model heater_board_model_i (.clock(clock), .sec1_on(p1), .sec2_on(p2),
    .sec1_sel({s12, s11, s10}), .sec2_sel({s22, s21, s20}), .duty(duty_o),
    .fault_pat(fault_pat), .fault_on(fault_on), .status(status));

  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Bounded wait for error pulse (0), section one permit (1) or low voltage warning (2)
  task automatic wait_on(input int which, input int lim, input logic must, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge clock);
      #1;
      seen = (which == 0) ? (error_valid === 1'b1) :
          (which == 1) ? (p1 === 1'b1) : (low_voltage_warn === 1'b1);
    end
    if (must && !seen) begin
      check("wait bound", 16'h1, 16'h0);
      tally_and_finish();
    end
  endtask

  task automatic restart(input logic cov, input logic [4:0] cnt, input logic [2:0] pat,
      input logic on);
    @(posedge clock);
    reset <= 1'b1;
    cover_open <= cov;
    stored_count <= cnt;
    fault_pat <= pat;
    fault_on <= on;
    heat_req_center <= 1'b1;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
  endtask

  task automatic t_drive();
    logic seen;
    restart(1'b0, 5'h01, PAT_HLL, 1'b0);
    wait_on(1, 400, 1'b1, seen);
    check("no repeat at one", 16'h0, {15'h0, repeated_fault});
    @(posedge clock);
    heat_req_center <= 1'b0;
    heat_req_ends <= 1'b1;
    power_req_center <= 3'h5;
    power_req_ends <= 3'h2;
    duty_req <= 1'b1;
    @(posedge clock);
    #1;
    check("permits", 16'h1, {14'h0, p1, p2});
    check("sels", 16'h2a, {10'h0, s12, s11, s10, s22, s21, s20});
    check("duty", 16'h1, {15'h0, duty_o});
    @(posedge clock);
    heat_req_center <= 1'b1;
    heat_req_ends <= 1'b0;
    duty_req <= 1'b0;
    @(posedge clock);
    #1;
    check("permits swap", 16'h2, {14'h0, p1, p2});
    check("duty off", 16'h0, {15'h0, duty_o});
    $display("test drive done");
  endtask

  // Normal-operation faults, one fresh run per pattern
  task automatic t_faults();
    logic [2:0] pats [5] = '{PAT_LLL, PAT_LLH, PAT_LHL, PAT_LHH, PAT_HHL};
    logic [15:0] codes [5] = '{CODE_C472, CODE_C473, CODE_C481, CODE_C480, CODE_C490};
    logic [4:0] cnts [5] = '{5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10};
    logic seen;
    for (int k = 0; k < 5; k++) begin
      restart(1'b0, 5'h00, PAT_HLL, 1'b0);
      wait_on(1, 400, 1'b1, seen);
      @(posedge clock);
      fault_pat <= pats[k];
      fault_on <= 1'b1;
      wait_on(0, 400, 1'b1, seen);
      check("code", codes[k], error_code);
      check("count", {11'h0, cnts[k]}, {11'h0, error_count});
      check("fault off", 16'h4, {13'h0, service_call, p1, p2});
      @(posedge clock);
      #1;
      check("pulse end", 16'h0, {15'h0, error_valid});
    end
    $display("test faults done");
  endtask

  task automatic t_low();
    logic seen;
    restart(1'b0, 5'h00, PAT_HLL, 1'b0);
    wait_on(1, 400, 1'b1, seen);
    @(posedge clock);
    fault_pat <= PAT_HHH;
    fault_on <= 1'b1;
    wait_on(2, 400, 1'b1, seen);
    check("warn", 16'h1, {15'h0, low_voltage_warn});
    check("warn no code", 16'h0, {13'h0, error_valid, service_call, error_count[0]});
    wait_on(0, 100, 1'b1, seen);
    check("deep low", CODE_C474, error_code);
    check("deep count", 16'h11, {11'h0, error_count});
    $display("test low voltage done");
  endtask

  task automatic t_init_cover();
    logic seen;
    restart(1'b0, 5'h00, PAT_LLL, 1'b1);
    wait_on(0, 400, 1'b1, seen);
    check("init code", CODE_C471, error_code);
    check("init count", 16'h0b, {11'h0, error_count});
    for (int x = 0; x < 2; x++) begin
      restart(1'b1, 5'h00, {2'b00, x[0]}, 1'b1);
      wait_on(0, 800, 1'b1, seen);
      check("cover code", CODE_C475, error_code);
      check("cover count", 16'h0a, {11'h0, error_count});
    end
    $display("test init and cover done");
  endtask

  task automatic t_repeat();
    restart(1'b0, 5'h02, PAT_HLL, 1'b0);
    repeat (5) @(posedge clock);
    #1;
    check("repeat", 16'h1, {15'h0, repeated_fault});
    check("repeat state", 16'h4, {13'h0, service_call, p1, p2});
    check("repeat code", CODE_NONE, error_code);
    $display("test repeat done");
  endtask

  // Short glitch then healthy pattern must log nothing
  task automatic t_glitch();
    logic seen;
    restart(1'b0, 5'h00, PAT_HLL, 1'b0);
    wait_on(1, 400, 1'b1, seen);
    @(posedge clock);
    fault_pat <= PAT_LLH;
    fault_on <= 1'b1;
    repeat (100) @(posedge clock);
    fault_on <= 1'b0;
    wait_on(0, 600, 1'b0, seen);
    check("glitch", 16'h0, {15'h0, seen});
    check("healthy", 16'h0, {error_code[14:0], service_call});
    // Cover open with line0 high must decode nothing
    @(posedge clock);
    cover_open <= 1'b1;
    wait_on(0, 300, 1'b0, seen);
    check("cover healthy", 16'h0, {15'h0, seen});
    check("cover no call", 16'h0, {15'h0, service_call});
    $display("test glitch done");
  endtask

  initial begin
    t_drive();
    t_faults();
    t_low();
    t_init_cover();
    t_repeat();
    t_glitch();
    tally_and_finish();
  end
endmodule
